//--- qd_params.svh
// constants for the quadrature filter and decoder block
//
// Contract
// [RQ1] sample each channel every rising edge into a four-bit history register
// [RQ2] filtered level changes only after three equal consecutive samples
// [RQ3] glitches between edges and pulses under two clocks are suppressed
// [RQ4] decoder compares previous and present filtered state, emits strobe and direction
// [RQ5] one, two or four counts per encoder cycle by resolution mode
// [RQ6] states: 10 is 1, 11 is 2, 01 is 3, 00 is 4
// [RQ7] four-times mode strobes on every valid transition either way
// [RQ8] two-times mode: up entering 1 or 3, down entering 2 or 4
// [RQ9] single mode: up entering 1, down entering 2, none at 3 or 4
// [RQ10] first channel leading means up, second leading means down
// [RQ11] both channels changing at once need not be flagged
// [RQ12] count pulses rise after rising edge, fall after next falling edge
// [RQ13] direction changes only on rising edges, stable across its pulse
// [RQ14] each axis has its own active-low clear input
// [RQ15] decoded count pulse lasts half a clock in the update cycle
// [RQ16] an accepted channel change reaches counting logic within seven clocks
// [RQ17] encoder leaves at least one clock between consecutive states
// [RQ18] static two-bit mode input selects four, two or single rate
// [RQ19] reset loads history and previous state from live inputs, no spurious count
`ifndef QD_PARAMS_SVH
`define QD_PARAMS_SVH

`define QD_HIST_W      4
`define QD_HIST_RST    4'h0
`define QD_MODE_W      2
`define QD_MODE_4X     2'h0
`define QD_MODE_2X     2'h1
`define QD_MODE_1X     2'h2
`define QD_SYNC_W      8
`define QD_SYNC_RST    8'h00
`define QD_POS_CLR_Y   7
`define QD_POS_CLR_X   6
`define QD_POS_MODE_HI 5
`define QD_POS_MODE_LO 4
`define QD_POS_Y_B     3
`define QD_POS_Y_A     2
`define QD_POS_X_B     1
`define QD_POS_X_A     0

`endif

//--- qd_pkg.sv
// types shared by the quadrature filter and decoder block
package qd_pkg;

  typedef enum logic [1:0] {
    MODE_4X,
    MODE_2X,
    MODE_1X
  } mode_t;

  typedef enum logic [1:0] {
    ST_ONE,
    ST_TWO,
    ST_THREE,
    ST_FOUR
  } quad_state_t;

endpackage : qd_pkg

//--- qd_link_if.sv
// link between one axis' filters and its decoder
`timescale 1ns/1ps
`default_nettype none
interface qd_link_if;
  logic filt_first;
  logic filt_second;
  logic load;
  logic step;
  logic up;

  modport feeder (
    output filt_first,
    output filt_second,
    output load,
    input  step,
    input  up
  );

  modport decoder (
    input  filt_first,
    input  filt_second,
    input  load,
    output step,
    output up
  );
endinterface : qd_link_if
`default_nettype wire

//--- qd_filter.sv
// three-sample stability filter for one quadrature channel
`timescale 1ns/1ps
`default_nettype none
`include "qd_params.svh"
module qd_filter (
  input  wire logic i_clk_sys,
  input  wire logic i_arst_n,
  input  wire logic i_load,
  input  wire logic i_sample,
  output logic      o_level
);
  logic [`QD_HIST_W-1:0] hist_r;
  logic [`QD_HIST_W-1:0] hist_nxt;
  logic                  level_r;
  logic                  level_nxt;

  always_comb begin
    hist_nxt  = {hist_r[`QD_HIST_W-2:0], i_sample}; // RQ1
    level_nxt = level_r;
    if (i_load) begin
      hist_nxt  = {`QD_HIST_W{i_sample}}; // RQ19
      level_nxt = i_sample;
    end else if (hist_r[3:1] == 3'h7) begin
      level_nxt = 1'b1; // RQ2 RQ3
    end else if (hist_r[3:1] == 3'h0) begin
      level_nxt = 1'b0; // RQ2 RQ3
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      hist_r  <= `QD_HIST_RST;
      level_r <= 1'b0;
    end else begin
      hist_r  <= hist_nxt;
      level_r <= level_nxt;
    end
  end

  assign o_level = level_r;
endmodule : qd_filter
`default_nettype wire

//--- qd_decoder.sv
// quadrature state decoder for one axis
`timescale 1ns/1ps
`default_nettype none
module qd_decoder (
  input  wire logic          i_clk_sys,
  input  wire logic          i_arst_n,
  input  wire qd_pkg::mode_t i_mode,
  qd_link_if.decoder         lk
);
  import qd_pkg::*;

  quad_state_t prev_r;
  quad_state_t prev_nxt;
  quad_state_t cur;
  logic        step_r;
  logic        step_nxt;
  logic        up_r;
  logic        up_nxt;
  logic        fwd;
  logic        back;

  function automatic quad_state_t succ(input quad_state_t s);
    unique case (s)
      ST_ONE:   succ = ST_TWO;
      ST_TWO:   succ = ST_THREE;
      ST_THREE: succ = ST_FOUR;
      ST_FOUR:  succ = ST_ONE;
    endcase
  endfunction : succ

  always_comb begin
    unique case ({lk.filt_first, lk.filt_second}) // RQ6
      2'h2: cur = ST_ONE;
      2'h3: cur = ST_TWO;
      2'h1: cur = ST_THREE;
      2'h0: cur = ST_FOUR;
    endcase
    // first leading walks 1-2-3-4; a double change matches neither and is dropped
    fwd      = (succ(prev_r) == cur); // RQ10 RQ11
    back     = (succ(cur) == prev_r); // RQ10 RQ11
    prev_nxt = cur; // RQ4
    up_nxt   = up_r;
    step_nxt = 1'b0;
    if (!lk.load && (fwd || back)) begin
      up_nxt = fwd; // RQ10
      unique case (i_mode) // RQ5
        MODE_4X: step_nxt = 1'b1; // RQ7
        MODE_2X: step_nxt = fwd ? (cur == ST_ONE || cur == ST_THREE)
                                : (cur == ST_TWO || cur == ST_FOUR); // RQ8
        MODE_1X: step_nxt = fwd ? (cur == ST_ONE) : (cur == ST_TWO); // RQ9
        default: step_nxt = 1'b1;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      prev_r <= ST_FOUR;
      step_r <= 1'b0;
      up_r   <= 1'b1;
    end else begin
      prev_r <= prev_nxt; // RQ19
      step_r <= step_nxt;
      up_r   <= up_nxt;
    end
  end

  assign lk.step = step_r;
  assign lk.up   = up_r;
endmodule : qd_decoder
`default_nettype wire

//--- quad_filter_decoder.sv
// dual-axis quadrature input filter and decoder with pulsed count outputs
`timescale 1ns/1ps
`default_nettype none
`include "qd_params.svh"
module quad_filter_decoder (
  input  wire logic                  i_clk_sys,
  input  wire logic                  i_arst_n,
  input  wire logic                  i_axis_one_clear_n,
  input  wire logic                  i_axis_two_clear_n,
  input  wire logic                  i_quad_input_first_one,
  input  wire logic                  i_quad_input_second_one,
  input  wire logic                  i_quad_input_first_two,
  input  wire logic                  i_quad_input_second_two,
  input  wire logic [`QD_MODE_W-1:0] i_count_mode,
  output logic                       o_direction_out_axis_one,
  output logic                       o_direction_out_axis_two,
  output logic                       o_decoded_pulse_axis_one,
  output logic                       o_decoded_pulse_axis_two,
  output logic                       o_carry_pulse_axis_one,
  output logic                       o_carry_pulse_axis_two
);
  import qd_pkg::*;

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  logic [`QD_SYNC_W-1:0] pin_raw;
  logic [`QD_SYNC_W-1:0] meta_r;
  logic [`QD_SYNC_W-1:0] sync_r;

  always_comb begin
    pin_raw                  = `QD_SYNC_RST;
    pin_raw[`QD_POS_X_A]     = i_quad_input_first_one;
    pin_raw[`QD_POS_X_B]     = i_quad_input_second_one;
    pin_raw[`QD_POS_Y_A]     = i_quad_input_first_two;
    pin_raw[`QD_POS_Y_B]     = i_quad_input_second_two;
    pin_raw[`QD_POS_MODE_LO] = i_count_mode[0];
    pin_raw[`QD_POS_MODE_HI] = i_count_mode[1];
    pin_raw[`QD_POS_CLR_X]   = i_axis_one_clear_n;
    pin_raw[`QD_POS_CLR_Y]   = i_axis_two_clear_n;
  end

  // clears synchronise from zero, but the channel bits turn live on the
  // same edge, so arm_r below stretches load until the seed is live
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      meta_r <= `QD_SYNC_RST;
      sync_r <= `QD_SYNC_RST;
    end else begin
      meta_r <= pin_raw;
      sync_r <= meta_r;
    end
  end

  // ************************************************************
  // resolution mode
  // ************************************************************
  mode_t mode_sel;

  always_comb begin
    unique case (sync_r[`QD_POS_MODE_HI:`QD_POS_MODE_LO]) // RQ18
      `QD_MODE_2X: mode_sel = MODE_2X;
      `QD_MODE_1X: mode_sel = MODE_1X;
      default:     mode_sel = MODE_4X;
    endcase
  end

  // ************************************************************
  // per-axis filter, decoder and output stage
  // ************************************************************
  logic [1:0] dir_q;
  logic [1:0] pulse_q;
  logic [1:0] carry_q;

  for (genvar ax = 0; ax < 2; ax++) begin : g_axis
    qd_link_if lk ();

    logic       load;
    logic [1:0] arm_r;
    logic [1:0] arm_nxt;
    logic       pend_r;
    logic       pend_nxt;
    logic       dir_r;
    logic       dir_nxt;
    logic       tog_r;
    logic       tog_nxt;
    logic       tog_neg_r;
    logic       carry_r;

    // two extra load edges: one to seed the filters from live samples,
    // one for the decoder to copy that seeded state
    assign load    = ~sync_r[`QD_POS_CLR_X + ax] | ~arm_r[1]; // RQ14 RQ19
    assign lk.load = load;

    qd_filter u_filt_first (
      .i_clk_sys (i_clk_sys),
      .i_arst_n  (i_arst_n),
      .i_load    (load),
      .i_sample  (sync_r[2*ax]),
      .o_level   (lk.filt_first)
    );

    qd_filter u_filt_second (
      .i_clk_sys (i_clk_sys),
      .i_arst_n  (i_arst_n),
      .i_load    (load),
      .i_sample  (sync_r[2*ax+1]),
      .o_level   (lk.filt_second)
    );

    qd_decoder u_dec (
      .i_clk_sys (i_clk_sys),
      .i_arst_n  (i_arst_n),
      .i_mode    (mode_sel),
      .lk        (lk)
    );

    // direction leads the pulse by a clock so it is settled at the rise
    always_comb begin
      arm_nxt  = {arm_r[0], sync_r[`QD_POS_CLR_X + ax]};
      pend_nxt = lk.step & ~load;
      dir_nxt  = lk.step ? lk.up : dir_r; // RQ13
      tog_nxt  = tog_r ^ (pend_r & ~load); // RQ16
      if (load) begin
        dir_nxt = dir_r;
      end
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
        arm_r   <= 2'h0;
        pend_r  <= 1'b0;
        dir_r   <= 1'b1;
        tog_r   <= 1'b0;
        carry_r <= 1'b0;
      end else begin
        arm_r   <= arm_nxt;
        pend_r  <= pend_nxt;
        dir_r   <= dir_nxt; // RQ13
        tog_r   <= tog_nxt;
        // no position counter here, so there is never a wrap to signal
        carry_r <= 1'b0;
      end
    end

    // the falling edge copies the toggle back and ends the pulse
    always_ff @(negedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
        tog_neg_r <= 1'b0;
      end else begin
        tog_neg_r <= tog_r;
      end
    end

    assign dir_q[ax]   = dir_r;
    // two flops on opposite edges instead of clock gating: a gated clock
    // would leave a sliver at the next rise while the flop clears
    assign pulse_q[ax] = tog_r ^ tog_neg_r; // RQ12 RQ15
    assign carry_q[ax] = carry_r & i_clk_sys; // RQ12
  end

  assign o_direction_out_axis_one = dir_q[0];
  assign o_direction_out_axis_two = dir_q[1];
  assign o_decoded_pulse_axis_one = pulse_q[0];
  assign o_decoded_pulse_axis_two = pulse_q[1];
  assign o_carry_pulse_axis_one   = carry_q[0];
  assign o_carry_pulse_axis_two   = carry_q[1];

endmodule : quad_filter_decoder
`default_nettype wire

//--- quad_filter_decoder_asserts.sv
// port-level checks for the quadrature filter and decoder
`timescale 1ns/1ps
`default_nettype none
module qfd_checker (
  input wire logic i_clk_sys,
  input wire logic i_arst_n,
  input wire logic i_axis_one_clear_n,
  input wire logic i_quad_input_first_one,
  input wire logic i_quad_input_second_one,
  input wire logic o_direction_out_axis_one,
  input wire logic o_direction_out_axis_two,
  input wire logic o_decoded_pulse_axis_one,
  input wire logic o_decoded_pulse_axis_two,
  input wire logic o_carry_pulse_axis_one,
  input wire logic o_carry_pulse_axis_two
);
  logic [3:0] quiet_r;
  logic [3:0] quiet_nxt;
  logic [1:0] pins_r;
  logic       dir_neg_r;
  // edges since axis one pins last moved, saturating
  always_comb begin
    quiet_nxt = (quiet_r == 4'hf) ? quiet_r : quiet_r + 4'h1;
    if ({i_quad_input_first_one, i_quad_input_second_one} != pins_r) quiet_nxt = 4'h0;
  end
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      quiet_r <= 4'h0;
      pins_r  <= 2'h0;
    end else begin
      quiet_r <= quiet_nxt;
      pins_r  <= {i_quad_input_first_one, i_quad_input_second_one};
    end
  end
  always_ff @(negedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) dir_neg_r <= 1'b1;
    else dir_neg_r <= o_direction_out_axis_one;
  end
  a_dec_one_low: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    !o_decoded_pulse_axis_one) else $error("pulse one high at rising edge");
  a_dec_two_low: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    !o_decoded_pulse_axis_two) else $error("pulse two high at rising edge");
  a_carry_stay_low: assert property (@(negedge i_clk_sys) disable iff (!i_arst_n)
    !o_carry_pulse_axis_one && !o_carry_pulse_axis_two) else $error("carry pulse seen");
  a_dir_one_hold: assert property (@(negedge i_clk_sys) disable iff (!i_arst_n)
    o_decoded_pulse_axis_one |-> $stable(o_direction_out_axis_one)) else $error("dir one moved");
  a_dir_two_hold: assert property (@(negedge i_clk_sys) disable iff (!i_arst_n)
    o_decoded_pulse_axis_two |-> $stable(o_direction_out_axis_two)) else $error("dir two moved");
  a_dir_rise_only: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    o_direction_out_axis_one == dir_neg_r) else $error("dir one moved in low phase");
  a_quiet_no_pulse: assert property (@(negedge i_clk_sys) disable iff (!i_arst_n)
    quiet_r >= 4'd14 |-> !o_decoded_pulse_axis_one) else $error("pulse without input move");
  a_clear_no_pulse: assert property (@(negedge i_clk_sys) disable iff (!i_arst_n)
    (!i_axis_one_clear_n)[*6] |-> !o_decoded_pulse_axis_one) else $error("pulse in clear");
endmodule : qfd_checker
`default_nettype wire

//--- quad_encoder_model.sv
// incremental encoder model driving one channel pair
`timescale 1ns/1ps
`default_nettype none
module quad_encoder_model (
  input  wire logic i_clk_sys,
  input  wire logic i_step,
  input  wire logic i_up,
  input  wire logic i_glitch,
  output logic      o_first,
  output logic      o_second
);
  logic [1:0] phase_r = 2'h0;
  // one state per request; requests come many clocks apart
  always @(posedge i_clk_sys) if (i_step) phase_r <= i_up ? phase_r + 2'h1 : phase_r - 2'h1;
  assign o_first  = (phase_r < 2'h2) ^ i_glitch;
  assign o_second = (phase_r == 2'h1) || (phase_r == 2'h2);
endmodule : quad_encoder_model
`default_nettype wire

//--- quad_filter_decoder_tb.sv
// self-checking bench for the quadrature filter and decoder
`timescale 1ns/1ps
`default_nettype none
`include "qd_params.svh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin bad_count++; \
  $display("unexpected %0t: value mismatch", $time); end end
module quad_filter_decoder_tb;
  logic       clk_sys;
  logic       arst_n;
  logic [1:0] clr_n = 2'b11;
  logic [1:0] step = 2'b00;
  logic [1:0] up = 2'b11;
  logic [1:0] glitch = 2'b00;
  logic [1:0] mode = `QD_MODE_4X;
  wire  [1:0] pin_a, pin_b, dir, dec, car;
  logic [1:0] dir_exp = 2'h3;
  int         seed = 12040;
  int         bad_count = 0;
  int         checked = 0;
  int         cnt [2] = '{0, 0};

  quad_filter_decoder dut_u (.i_clk_sys(clk_sys), .i_arst_n(arst_n),
    .i_axis_one_clear_n(clr_n[0]), .i_axis_two_clear_n(clr_n[1]),
    .i_quad_input_first_one(pin_a[0]), .i_quad_input_second_one(pin_b[0]),
    .i_quad_input_first_two(pin_a[1]), .i_quad_input_second_two(pin_b[1]),
    .i_count_mode(mode), .o_direction_out_axis_one(dir[0]), .o_direction_out_axis_two(dir[1]),
    .o_decoded_pulse_axis_one(dec[0]), .o_decoded_pulse_axis_two(dec[1]),
    .o_carry_pulse_axis_one(car[0]), .o_carry_pulse_axis_two(car[1]));
  quad_encoder_model enc_one (.i_clk_sys(clk_sys), .i_step(step[0]), .i_up(up[0]),
    .i_glitch(glitch[0]), .o_first(pin_a[0]), .o_second(pin_b[0]));
  quad_encoder_model enc_two (.i_clk_sys(clk_sys), .i_step(step[1]), .i_up(up[1]),
    .i_glitch(glitch[1]), .o_first(pin_a[1]), .o_second(pin_b[1]));

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  // pulses only show in the high phase; look a quarter period after the rise,
  // clear of both edges that shape them
  always begin
    @(posedge clk_sys);
    #25;
    for (int k = 0; k < 2; k++) if (dec[k] === 1'b1) cnt[k]++;
  end

  // counts expected on entering phase p (0 is state 1) in mode m
  function automatic int exp_cnt(logic [1:0] m, logic [1:0] p, logic u);
    if (m == `QD_MODE_2X) return (u == !p[0]) ? 1 : 0;
    if (m == `QD_MODE_1X) return (!p[1] && u == !p[0]) ? 1 : 0;
    return 1;
  endfunction : exp_cnt

  task automatic move(input logic [1:0] go, input logic [1:0] en);
    int         base [2];
    logic [1:0] u;
    base = cnt;
    u = 2'($random(seed));
    up <= u;
    step <= go;
    @(posedge clk_sys);
    step <= 2'b00;
    repeat (16) @(posedge clk_sys);
    for (int k = 0; k < 2; k++) begin
      logic [1:0] p;
      p = k ? enc_two.phase_r : enc_one.phase_r;
      `CHK(cnt[k] - base[k], (go[k] && en[k]) ? exp_cnt(mode, p, u[k]) : 0)
      // direction follows counted transitions only
      if (go[k] && en[k] && exp_cnt(mode, p, u[k]) == 1) dir_exp[k] = u[k];
      `CHK(dir[k], dir_exp[k])
    end
  endtask : move

  task automatic spike(input int len);
    int base [2];
    base = cnt;
    glitch <= 2'b11;
    repeat (len) @(posedge clk_sys);
    glitch <= 2'b00;
    repeat (16) @(posedge clk_sys);
    `CHK(cnt[0] + cnt[1], base[0] + base[1])
  endtask : spike

  task report_and_stop;
    if (bad_count == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : report_and_stop

  initial begin
    #(6000 * 100);
    bad_count++;
    report_and_stop;
  end

  initial begin
    arst_n <= 1'h0;
    repeat (3) @(posedge clk_sys);
    `CHK({dir, dec, car}, 6'h30)
    repeat (3) @(posedge clk_sys);
    arst_n <= 1'h1;
    // long enough for a false seed to pass the filter and reach a pulse
    repeat (16) @(posedge clk_sys);
    `CHK(cnt[0] + cnt[1], 0)
    for (int m = 0; m < 4; m++) begin
      mode <= m[1:0];
      repeat (4) @(posedge clk_sys);
      for (int i = 0; i < 20; i++) move(2'b11, 2'b11);
    end
    mode <= `QD_MODE_4X;
    spike(1);
    spike(2);
    for (int k = 0; k < 2; k++) begin
      clr_n <= 2'b11 ^ (2'b01 << k);
      move(2'b11, 2'b11 ^ (2'b01 << k));
      clr_n <= 2'b11;
      repeat (4) @(posedge clk_sys);
      move(2'b11, 2'b11);
    end
    report_and_stop;
  end
endmodule : quad_filter_decoder_tb
bind quad_filter_decoder qfd_checker chk_u (.i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n),
  .i_axis_one_clear_n(i_axis_one_clear_n), .i_quad_input_first_one(i_quad_input_first_one),
  .i_quad_input_second_one(i_quad_input_second_one),
  .o_direction_out_axis_one(o_direction_out_axis_one),
  .o_direction_out_axis_two(o_direction_out_axis_two),
  .o_decoded_pulse_axis_one(o_decoded_pulse_axis_one),
  .o_decoded_pulse_axis_two(o_decoded_pulse_axis_two),
  .o_carry_pulse_axis_one(o_carry_pulse_axis_one), .o_carry_pulse_axis_two(o_carry_pulse_axis_two));
`default_nettype wire
